// ===== src/dacmu_cfg.svh
// register offsets, field positions and reset values for the dac mu control/status bank
`ifndef DACMU_CFG_SVH
`define DACMU_CFG_SVH
`define DACMU_ADDR_SMP_LO 8'h19
`define DACMU_ADDR_SMP_HI 8'h1a
`define DACMU_ADDR_PHASE 8'h1b
`define DACMU_ADDR_CLKIN_LO 8'h1b
`define DACMU_ADDR_CLKIN_HI 8'h1c
`define DACMU_ADDR_LOCK 8'h21
`define DACMU_ADDR_DUTY 8'h22
`define DACMU_ADDR_CROSS 8'h23
`define DACMU_ADDR_PDET 8'h24
`define DACMU_ADDR_MUDUTY 8'h25
`define DACMU_ADDR_MUCFG 8'h26
`define DACMU_ADDR_MUSRCH 8'h27
`define DACMU_ADDR_DELAY_CTRL_DELAY_VALUE_HI 8'h28
`define DACMU_ADDR_MUSTAT 8'h2a
`define DACMU_BIT_SYNC_TRK 7
`define DACMU_BIT_SYNC_LOST_FLAG 5
`define DACMU_BIT_SYNC_LOCKED_FLAG 4
`define DACMU_BIT_RCVR_TRK 3
`define DACMU_BIT_RECEIVER_LOST_FLAG 1
`define DACMU_BIT_RECEIVER_LOCKED_FLAG 0
`define DACMU_BIT_DUTY_EN 4
`define DACMU_BIT_CROSS_AUTO 7
`define DACMU_BIT_CROSS_ON 4
`define DACMU_BIT_CROSS_DIR 3
`define DACMU_BIT_BOOST 5
`define DACMU_BIT_PDET 4
`define DACMU_BIT_MUDUTY 7
`define DACMU_RST_MUCFG 8'h42
`define DACMU_RST_ZERO 8'h00
`define DACMU_DELAY_CTRL_DELAY_VALUE_MAX 9'h1_b0
`define DACMU_PHASE_MAX 5'h1_0
`endif

// ===== src/dacmu_pkg.sv
// types for the dac mu control/status bank
package dacmu_pkg;
    typedef enum logic [1:0] {
        DACMU_SEARCH_TRACK,
        DACMU_SEARCH_ONLY,
        DACMU_TRACK_ONLY,
        DACMU_MODE_RSVD
    } dacmu_mode_t;
    typedef struct packed {
        logic sync_tracking_flag;
        logic sync_locked_flag;
        logic receiver_tracking_flag;
        logic receiver_locked_flag;
    } dacmu_lock_t;
    typedef struct packed {
        logic duty_en;
        logic cross_auto;
        logic cross_on;
        logic cross_dir;
        logic [2:0] cross_offset;
    } dacmu_clkctl_t;
    typedef struct packed {
        logic enable;
        logic slope;
        logic [1:0] mode;
        logic [1:0] gain;
        logic [1:0] search_direction;
        logic [4:0] target_phase;
        logic [8:0] delay_ctrl_delay_value;
        logic comparator_boost_bias;
        logic phase_detector_enable;
        logic delay_ctrl_duty_enable;
    } dacmu_muctl_t;
endpackage

// ===== src/dacmu_regs.sv
// configuration and status register bank of the dac receiver and mu controllers
`timescale 1ns/10ps
`include "dacmu_cfg.svh"
// Contract
// - sample delay 10-bit value read back across 0x19 and 0x1A once tracking.
// - clock-in delay 10-bit value read back, normally equal to sample delay.
// - two-bit sync output phase select read back at bits 3:2.
// - two-bit divider phase status read back at bits 1:0.
// - tracking flags for sync and receiver read 1 once tracking established.
// - lock flags for sync and receiver read 1 while locked.
// - lost-lock flags stick at 1 after any lock loss until cleared.
// - duty-cycle loop runs while its enable bit is 1.
// - crossing-auto 1 applies crossing control without signal; 0 only with signal.
// - crossing loop runs while its enable bit is 1.
// - crossing direction 1 lowers, 0 raises the crossing point.
// - three-bit crossing offset scales adjustment range, zeros smallest.
// - slope bit picks negative 0 or positive 1 lock, resets positive.
// - mode field selects search-track, search-only or track-only.
// - read-select 1 returns current mu delay through the delay fields.
// - two-bit tracking gain resets to 01.
// - mu controller runs only while its enable bit is 1.
// - mu delay lsb sits in bit 7 of a separate register.
// - search direction selects down, up or down-then-up.
// - five-bit target phase, valid up to 16.
// - disabled mu delay sets the delay up to 432; enabled it seeds search.
// - mu lock flag reads 1 while locked.
module dacmu_regs (
    // clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // serial port register access, already deserialised
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // receiver and sync controller status
    input wire logic [9:0] sample_delay_value,
    input wire logic [9:0] clock_in_delay_value,
    input wire logic [1:0] sync_output_phase,
    input wire logic [1:0] divider_phase,
    input wire dacmu_pkg::dacmu_lock_t lock_in,
    input wire logic lost_flag_clear,
    // mu controller status
    input wire logic [8:0] delay_ctrl_current,
    input wire logic delay_ctrl_locked_in,
    input wire logic input_signal_detect,
    // control out
    output dacmu_pkg::dacmu_clkctl_t clkctl,
    output logic duty_loop_run,
    output logic cross_loop_run,
    output dacmu_pkg::dacmu_muctl_t muctl,
    output logic [8:0] delay_ctrl_setting,
    output logic delay_ctrl_run
);
    import dacmu_pkg::*;

    logic sync_lost_ff;
    logic rcvr_lost_ff;
    logic [1:0] track_q_ff;
    logic [1:0] lock_q_ff;
    logic [7:0] nxt_rdata;
    logic [8:0] mu_readback;
    logic [8:0] nxt_delay;
    localparam logic [7:0] mucfg_rst = `DACMU_RST_MUCFG;

    // clock input loop controls
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clkctl <= '0;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == `DACMU_ADDR_DUTY) begin
                clkctl.duty_en <= reg_wdata[`DACMU_BIT_DUTY_EN];
            end
            if (reg_addr == `DACMU_ADDR_CROSS) begin
                clkctl.cross_auto <= reg_wdata[`DACMU_BIT_CROSS_AUTO];
                clkctl.cross_on <= reg_wdata[`DACMU_BIT_CROSS_ON];
                clkctl.cross_dir <= reg_wdata[`DACMU_BIT_CROSS_DIR];
                clkctl.cross_offset <= reg_wdata[2:0];
            end
        end
    end

    // loop run qualifiers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            duty_loop_run <= 1'b0;
            cross_loop_run <= 1'b0;
        end else if (clk_en) begin
            duty_loop_run <= clkctl.duty_en;
            // without auto, crossing control waits for a detected input
            cross_loop_run <= clkctl.cross_on && (clkctl.cross_auto || input_signal_detect);
        end
    end

    // mu controller configuration
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            muctl <= '0;
            muctl.slope <= mucfg_rst[6];
            muctl.gain <= mucfg_rst[2:1];
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `DACMU_ADDR_PDET: begin
                    muctl.comparator_boost_bias <= reg_wdata[`DACMU_BIT_BOOST];
                    muctl.phase_detector_enable <= reg_wdata[`DACMU_BIT_PDET];
                end
                `DACMU_ADDR_MUDUTY: begin
                    muctl.delay_ctrl_duty_enable <= reg_wdata[`DACMU_BIT_MUDUTY];
                end
                `DACMU_ADDR_MUCFG: begin
                    muctl.slope <= reg_wdata[6];
                    muctl.mode <= reg_wdata[5:4];
                    muctl.gain <= reg_wdata[2:1];
                    muctl.enable <= reg_wdata[0];
                end
                `DACMU_ADDR_MUSRCH: begin
                    muctl.delay_ctrl_delay_value[0] <= reg_wdata[7];
                    muctl.search_direction <= reg_wdata[6:5];
                    muctl.target_phase <= reg_wdata[4:0];
                end
                `DACMU_ADDR_DELAY_CTRL_DELAY_VALUE_HI: begin
                    muctl.delay_ctrl_delay_value[8:1] <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // read bit kept separately since muctl has no slot for it
    logic read_sel_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            read_sel_ff <= 1'b0;
        end else if (clk_en && reg_wr && reg_addr == `DACMU_ADDR_MUCFG) begin
            read_sel_ff <= reg_wdata[3];
        end
    end

    // clamp direct delay to the line's last tap
    always_comb begin
        nxt_delay = muctl.delay_ctrl_delay_value;
        if (!muctl.enable && nxt_delay > `DACMU_DELAY_CTRL_DELAY_VALUE_MAX) begin
            nxt_delay = `DACMU_DELAY_CTRL_DELAY_VALUE_MAX;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            delay_ctrl_setting <= '0;
            delay_ctrl_run <= 1'b0;
        end else if (clk_en) begin
            delay_ctrl_setting <= nxt_delay;
            delay_ctrl_run <= muctl.enable;
        end
    end

    // lost-lock: a falling lock sets the flag, and the set beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lock_q_ff <= '0;
            track_q_ff <= '0;
            sync_lost_ff <= 1'b0;
            rcvr_lost_ff <= 1'b0;
        end else if (clk_en) begin
            lock_q_ff <= {lock_in.sync_locked_flag, lock_in.receiver_locked_flag};
            track_q_ff <= {lock_in.sync_tracking_flag, lock_in.receiver_tracking_flag};
            if (lock_q_ff[1] && !lock_in.sync_locked_flag) begin
                sync_lost_ff <= 1'b1;
            end else if (lost_flag_clear) begin
                sync_lost_ff <= 1'b0;
            end
            if (lock_q_ff[0] && !lock_in.receiver_locked_flag) begin
                rcvr_lost_ff <= 1'b1;
            end else if (lost_flag_clear) begin
                rcvr_lost_ff <= 1'b0;
            end
        end
    end

    // mu delay as seen by the read fields
    assign mu_readback = read_sel_ff ? delay_ctrl_current : muctl.delay_ctrl_delay_value;

    always_comb begin
        nxt_rdata = `DACMU_RST_ZERO;
        case (reg_addr)
            `DACMU_ADDR_SMP_LO: nxt_rdata = {sample_delay_value[1:0], 6'h00};
            `DACMU_ADDR_SMP_HI: nxt_rdata = sample_delay_value[9:2];
            `DACMU_ADDR_PHASE: nxt_rdata = {clock_in_delay_value[1:0], 2'b00, sync_output_phase, divider_phase};
            `DACMU_ADDR_CLKIN_HI: nxt_rdata = clock_in_delay_value[9:2];
            `DACMU_ADDR_LOCK: begin
                nxt_rdata[`DACMU_BIT_SYNC_TRK] = track_q_ff[1];
                nxt_rdata[`DACMU_BIT_SYNC_LOST_FLAG] = sync_lost_ff;
                nxt_rdata[`DACMU_BIT_SYNC_LOCKED_FLAG] = lock_q_ff[1];
                nxt_rdata[`DACMU_BIT_RCVR_TRK] = track_q_ff[0];
                nxt_rdata[`DACMU_BIT_RECEIVER_LOST_FLAG] = rcvr_lost_ff;
                nxt_rdata[`DACMU_BIT_RECEIVER_LOCKED_FLAG] = lock_q_ff[0];
            end
            `DACMU_ADDR_DUTY: nxt_rdata[`DACMU_BIT_DUTY_EN] = clkctl.duty_en;
            `DACMU_ADDR_CROSS: nxt_rdata = {clkctl.cross_auto, 2'b00, clkctl.cross_on, clkctl.cross_dir,
                clkctl.cross_offset};
            `DACMU_ADDR_PDET: nxt_rdata = {2'b00, muctl.comparator_boost_bias, muctl.phase_detector_enable, 4'h0};
            `DACMU_ADDR_MUDUTY: nxt_rdata = {muctl.delay_ctrl_duty_enable, 7'h00};
            `DACMU_ADDR_MUCFG: nxt_rdata = {1'b0, muctl.slope, muctl.mode, read_sel_ff, muctl.gain, muctl.enable};
            `DACMU_ADDR_MUSRCH: nxt_rdata = {mu_readback[0], muctl.search_direction, muctl.target_phase};
            `DACMU_ADDR_DELAY_CTRL_DELAY_VALUE_HI: nxt_rdata = mu_readback[8:1];
            `DACMU_ADDR_MUSTAT: nxt_rdata = {7'h00, delay_ctrl_locked_in};
            default: nxt_rdata = `DACMU_RST_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= nxt_rdata;
            end
        end
    end

    // checks
    sequence s_lock_fall_sync;
        lock_q_ff[1] && !lock_in.sync_locked_flag && clk_en;
    endsequence

    sequence s_lock_fall_rcvr;
        lock_q_ff[0] && !lock_in.receiver_locked_flag && clk_en;
    endsequence

    sequence s_wr_duty;
        clk_en && reg_wr && reg_addr == `DACMU_ADDR_DUTY;
    endsequence

    sequence s_wr_cross;
        clk_en && reg_wr && reg_addr == `DACMU_ADDR_CROSS;
    endsequence

    sequence s_wr_pdet;
        clk_en && reg_wr && reg_addr == `DACMU_ADDR_PDET;
    endsequence

    sequence s_wr_muduty;
        clk_en && reg_wr && reg_addr == `DACMU_ADDR_MUDUTY;
    endsequence

    sequence s_wr_mucfg;
        clk_en && reg_wr && reg_addr == `DACMU_ADDR_MUCFG;
    endsequence

    sequence s_wr_musrch;
        clk_en && reg_wr && reg_addr == `DACMU_ADDR_MUSRCH;
    endsequence

    sequence s_wr_delay_ctrl_delay_value_hi;
        clk_en && reg_wr && reg_addr == `DACMU_ADDR_DELAY_CTRL_DELAY_VALUE_HI;
    endsequence

    sequence s_rd_lock;
        clk_en && reg_rd && reg_addr == `DACMU_ADDR_LOCK;
    endsequence

    chk_sync_lost_set: assert property (@(posedge clk) disable iff (sys_rst)
        s_lock_fall_sync |=> sync_lost_ff) else $error("sync lost flag not set");

    chk_rcvr_lost_set: assert property (@(posedge clk) disable iff (sys_rst)
        s_lock_fall_rcvr |=> rcvr_lost_ff) else $error("receiver lost flag not set");

    chk_rcvr_lost_hold: assert property (@(posedge clk) disable iff (sys_rst)
        rcvr_lost_ff && !lost_flag_clear |=> rcvr_lost_ff) else $error("receiver lost flag dropped");

    chk_sync_lost_hold: assert property (@(posedge clk) disable iff (sys_rst)
        sync_lost_ff && !lost_flag_clear |=> sync_lost_ff) else $error("sync lost flag dropped");

    chk_sync_lost_clear: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && lost_flag_clear && !(lock_q_ff[1] && !lock_in.sync_locked_flag) |=> !sync_lost_ff)
        else $error("sync lost flag not cleared");

    chk_cross_run_gate: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && cross_loop_run |-> $past(clkctl.cross_on)) else $error("crossing loop ran disabled");

    chk_cross_auto_gate: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && cross_loop_run && !$past(clkctl.cross_auto) |-> $past(input_signal_detect))
        else $error("crossing ran without signal");

    chk_duty_run_gate: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en |=> duty_loop_run == $past(clkctl.duty_en) || !$past(clk_en)) else $error("duty loop mismatch");

    chk_delay_clamp: assert property (@(posedge clk) disable iff (sys_rst)
        !delay_ctrl_run |-> delay_ctrl_setting <= `DACMU_DELAY_CTRL_DELAY_VALUE_MAX || muctl.enable || $past(muctl.enable))
        else $error("direct delay above limit");

    chk_delay_direct: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !muctl.enable && muctl.delay_ctrl_delay_value <= `DACMU_DELAY_CTRL_DELAY_VALUE_MAX
        |=> delay_ctrl_setting == $past(muctl.delay_ctrl_delay_value)) else $error("direct delay not applied");

    chk_delay_seed: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && muctl.enable |=> delay_ctrl_setting == $past(muctl.delay_ctrl_delay_value))
        else $error("search seed not passed");

    chk_lock_read: assert property (@(posedge clk) disable iff (sys_rst)
        s_rd_lock |=> reg_rvalid && reg_rdata[0] == $past(lock_q_ff[0])) else $error("receiver lock read wrong");

    chk_sync_lock_read: assert property (@(posedge clk) disable iff (sys_rst)
        s_rd_lock |=> reg_rdata[4] == $past(lock_q_ff[1])) else $error("sync lock read wrong");

    chk_track_read: assert property (@(posedge clk) disable iff (sys_rst)
        s_rd_lock |=> reg_rdata[7] == $past(track_q_ff[1]) && reg_rdata[3] == $past(track_q_ff[0]))
        else $error("tracking read wrong");

    chk_lost_read: assert property (@(posedge clk) disable iff (sys_rst)
        s_rd_lock |=> reg_rdata[5] == $past(sync_lost_ff) && reg_rdata[1] == $past(rcvr_lost_ff))
        else $error("lost flag read wrong");

    chk_mu_lock_read: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && reg_rd && reg_addr == `DACMU_ADDR_MUSTAT |=> reg_rdata[0] == $past(delay_ctrl_locked_in))
        else $error("mu lock read wrong");

    chk_smp_lo_read: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && reg_rd && reg_addr == `DACMU_ADDR_SMP_LO |=> reg_rdata[7:6] == $past(sample_delay_value[1:0]))
        else $error("sample delay low read wrong");

    chk_smp_hi_read: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && reg_rd && reg_addr == `DACMU_ADDR_SMP_HI |=> reg_rdata == $past(sample_delay_value[9:2]))
        else $error("sample delay high read wrong");

    chk_phase_read: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && reg_rd && reg_addr == `DACMU_ADDR_PHASE
        |=> reg_rdata[3:2] == $past(sync_output_phase) && reg_rdata[1:0] == $past(divider_phase))
        else $error("phase status read wrong");

    chk_clkin_lo_read: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && reg_rd && reg_addr == `DACMU_ADDR_PHASE |=> reg_rdata[7:6] == $past(clock_in_delay_value[1:0]))
        else $error("clock-in delay low read wrong");

    chk_clkin_hi_read: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && reg_rd && reg_addr == `DACMU_ADDR_CLKIN_HI |=> reg_rdata == $past(clock_in_delay_value[9:2]))
        else $error("clock-in delay high read wrong");

    chk_rvalid_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && reg_rd |=> reg_rvalid) else $error("read not answered");

    chk_rvalid_idle: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !reg_rd |=> !reg_rvalid) else $error("answer without read");

    chk_delay_ctrl_delay_value_read_sel: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && reg_rd && reg_addr == `DACMU_ADDR_DELAY_CTRL_DELAY_VALUE_HI && read_sel_ff
        |=> reg_rdata == $past(delay_ctrl_current[8:1])) else $error("current mu delay not read back");

    chk_duty_en_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_duty |=> clkctl.duty_en == $past(reg_wdata[4])) else $error("duty enable not written");

    chk_cross_auto_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_cross |=> clkctl.cross_auto == $past(reg_wdata[7])) else $error("crossing auto not written");

    chk_cross_on_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_cross |=> clkctl.cross_on == $past(reg_wdata[4])) else $error("crossing enable not written");

    chk_cross_dir_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_cross |=> clkctl.cross_dir == $past(reg_wdata[3])) else $error("crossing direction not written");

    chk_cross_off_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_cross |=> clkctl.cross_offset == $past(reg_wdata[2:0])) else $error("crossing offset not written");

    chk_boost_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_pdet |=> muctl.comparator_boost_bias == $past(reg_wdata[5]) &&
        muctl.phase_detector_enable == $past(reg_wdata[4])) else $error("bias bits not written");

    chk_muduty_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_muduty |=> muctl.delay_ctrl_duty_enable == $past(reg_wdata[7])) else $error("mu duty not written");

    chk_slope_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_mucfg |=> muctl.slope == $past(reg_wdata[6])) else $error("slope not written");

    chk_mode_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_mucfg |=> muctl.mode == $past(reg_wdata[5:4])) else $error("mode not written");

    chk_read_sel_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_mucfg |=> read_sel_ff == $past(reg_wdata[3])) else $error("read select not written");

    chk_gain_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_mucfg |=> muctl.gain == $past(reg_wdata[2:1])) else $error("gain not written");

    chk_enable_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_mucfg |=> muctl.enable == $past(reg_wdata[0])) else $error("mu enable not written");

    chk_delay_ctrl_delay_value_lsb_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_musrch |=> muctl.delay_ctrl_delay_value[0] == $past(reg_wdata[7])) else $error("mu delay lsb lost");

    chk_delay_ctrl_delay_value_hi_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_delay_ctrl_delay_value_hi |=> muctl.delay_ctrl_delay_value[8:1] == $past(reg_wdata)) else $error("mu delay high lost");

    chk_srch_dir_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_musrch |=> muctl.search_direction == $past(reg_wdata[6:5])) else $error("search direction lost");

    chk_target_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_musrch |=> muctl.target_phase == $past(reg_wdata[4:0])) else $error("target phase lost");

    chk_mu_run_en: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !muctl.enable ##1 clk_en |-> !delay_ctrl_run) else $error("mu ran disabled");

    chk_mu_run_on: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && muctl.enable |=> delay_ctrl_run) else $error("mu did not run");

    // frozen enable must leave muctl, clkctl and reg_rvalid alone
    chk_freeze_cfg: assert property (@(posedge clk) disable iff (sys_rst)
        !clk_en |=> $stable(muctl) && $stable(clkctl) && $stable(reg_rvalid)) else $error("state moved while frozen");
endmodule

// ===== dv/dacmu_regs_tb.sv
// self-checking bench for the dac mu control/status register bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module dacmu_regs_tb;
    import dacmu_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [9:0] sample_delay_value = 10'h2_a5;
    logic [9:0] clock_in_delay_value = 10'h1_9e;
    logic [1:0] sync_output_phase = 2'h2;
    logic [1:0] divider_phase = 2'h1;
    dacmu_lock_t lock_in = 4'h0;
    logic lost_flag_clear = 1'b0;
    logic [8:0] delay_ctrl_current = 9'h1_55;
    logic delay_ctrl_locked_in = 1'b0;
    logic input_signal_detect = 1'b0;
    dacmu_clkctl_t clkctl;
    logic duty_loop_run;
    logic cross_loop_run;
    dacmu_muctl_t muctl;
    logic [8:0] delay_ctrl_setting;
    logic delay_ctrl_run;
    int miscompares = 0;
    int check_count = 0;
    // each row: address, write data, expected read-back
    logic [23:0] rows [13];
    always #10 clk = ~clk;
    dacmu_regs i_dacmu_regs (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sample_delay_value(sample_delay_value), .clock_in_delay_value(clock_in_delay_value),
        .sync_output_phase(sync_output_phase), .divider_phase(divider_phase), .lock_in(lock_in),
        .lost_flag_clear(lost_flag_clear), .delay_ctrl_current(delay_ctrl_current),
        .delay_ctrl_locked_in(delay_ctrl_locked_in), .input_signal_detect(input_signal_detect),
        .clkctl(clkctl), .duty_loop_run(duty_loop_run), .cross_loop_run(cross_loop_run), .muctl(muctl),
        .delay_ctrl_setting(delay_ctrl_setting), .delay_ctrl_run(delay_ctrl_run));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        tick(1);
        reg_wr = 1'b0;
    endtask
    // strobe lasts one cycle, answer is looked at just after the same edge that samples it
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        tick(1);
        reg_rd = 1'b1;
        reg_addr = a;
        tick(1);
        reg_rd = 1'b0;
        `CHK("rvalid", 1'b1, reg_rvalid)
        `CHK($sformatf("reg %h", a), e, reg_rdata)
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
    initial begin
        rows[0] = {8'h22, 8'h10, 8'h10};
        rows[1] = {8'h23, 8'h9f, 8'h9f};
        rows[2] = {8'h23, 8'h08, 8'h08};
        rows[3] = {8'h24, 8'h30, 8'h30};
        rows[4] = {8'h25, 8'h80, 8'h80};
        rows[5] = {8'h26, 8'h41, 8'h41};
        rows[6] = {8'h26, 8'h14, 8'h14};
        rows[7] = {8'h26, 8'h26, 8'h26};
        rows[8] = {8'h27, 8'hd0, 8'hd0};
        rows[9] = {8'h27, 8'h20, 8'h20};
        rows[10] = {8'h27, 8'h0f, 8'h0f};
        rows[11] = {8'h21, 8'hff, 8'h00};
        rows[12] = {8'h30, 8'h5a, 8'h00};
        tick(4);
        sys_rst = 1'b0;
        rd_chk(8'h26, 8'h42);
        for (int a = 8'h22; a <= 8'h27; a++) begin
            if (a != 8'h26) rd_chk(a[7:0], 8'h00);
        end
        `CHK("slope", 1'b1, muctl.slope)
        `CHK("run", 1'b0, delay_ctrl_run)
        $display("test reset done");
        for (int i = 0; i < 13; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd_chk(rows[i][23:16], rows[i][7:0]);
        end
        $display("test table done");
        rd_chk(8'h19, {sample_delay_value[1:0], 6'h00});
        rd_chk(8'h1a, sample_delay_value[9:2]);
        rd_chk(8'h1b, {clock_in_delay_value[1:0], 2'h0, sync_output_phase, divider_phase});
        rd_chk(8'h1c, clock_in_delay_value[9:2]);
        $display("test status done");
        lock_in = 4'hf;
        tick(2);
        rd_chk(8'h21, 8'h99);
        lock_in = 4'ha;
        tick(3);
        rd_chk(8'h21, 8'haa);
        lock_in = 4'hf;
        tick(2);
        rd_chk(8'h21, 8'hbb);
        lost_flag_clear = 1'b1;
        tick(1);
        lost_flag_clear = 1'b0;
        tick(1);
        rd_chk(8'h21, 8'h99);
        delay_ctrl_locked_in = 1'b1;
        tick(2);
        rd_chk(8'h2a, 8'h01);
        $display("test lock done");
        wr(8'h22, 8'h10);
        wr(8'h23, 8'h10);
        tick(2);
        `CHK("duty run", 1'b1, duty_loop_run)
        `CHK("cross run", 1'b0, cross_loop_run)
        input_signal_detect = 1'b1;
        tick(2);
        `CHK("cross run", 1'b1, cross_loop_run)
        wr(8'h23, 8'h90);
        wr(8'h22, 8'h00);
        input_signal_detect = 1'b0;
        tick(2);
        `CHK("cross run", 1'b1, cross_loop_run)
        `CHK("duty run", 1'b0, duty_loop_run)
        `CHK("clkctl", 7'h30, clkctl)
        wr(8'h23, 8'h80);
        tick(2);
        `CHK("cross run", 1'b0, cross_loop_run)
        $display("test loops done");
        wr(8'h26, 8'h00);
        wr(8'h28, 8'hff);
        wr(8'h27, 8'h80);
        tick(2);
        `CHK("setting", 9'h1_b0, delay_ctrl_setting)
        wr(8'h28, 8'h6c);
        wr(8'h27, 8'h00);
        tick(2);
        `CHK("setting", 9'h0_d8, delay_ctrl_setting)
        rd_chk(8'h28, 8'h6c);
        wr(8'h26, 8'h08);
        rd_chk(8'h28, delay_ctrl_current[8:1]);
        rd_chk(8'h27, {delay_ctrl_current[0], 7'h00});
        wr(8'h26, 8'h01);
        tick(2);
        `CHK("run", 1'b1, delay_ctrl_run)
        `CHK("enable", 1'b1, muctl.enable)
        $display("test delay done");
        // a frozen clock enable must swallow the write
        clk_en = 1'b0;
        wr(8'h26, 8'h00);
        clk_en = 1'b1;
        rd_chk(8'h26, 8'h01);
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        rd_chk(8'h26, 8'h42);
        rd_chk(8'h22, 8'h00);
        $display("test rerun done");
        wrap_up();
    end
endmodule
